// ==== include/pfmc_pkg.sv ====
// Package for the parallel flash host controller: register map, bus timing, pin structs.
// Assumes a 100 MHz APB clock and an asynchronous parallel NOR flash on the far side.
`default_nettype none
package pfmc_pkg;
	// ---------------------------------------------------------------
	// Register map (byte offsets)
	// ---------------------------------------------------------------
	localparam logic [7:0] PFMC_CTRL_OFF = 8'h00;
	localparam logic [7:0] PFMC_ADDR_OFF = 8'h04;
	localparam logic [7:0] PFMC_WDATA_OFF = 8'h08;
	localparam logic [7:0] PFMC_RDATA_OFF = 8'h0c;
	localparam logic [7:0] PFMC_STAT_OFF = 8'h10;
	// CTRL fields
	localparam int PFMC_CMD_LSB = 0;
	localparam int PFMC_CMD_W = 3;
	localparam int PFMC_WORD_BIT = 4;
	localparam int PFMC_HV_BIT = 5;
	// STAT fields
	localparam int PFMC_BUSY_BIT = 0;
	localparam int PFMC_TOUT_BIT = 1;
	localparam int PFMC_PROT_BIT = 2;
	// ---------------------------------------------------------------
	// Commands and flash command codes
	// ---------------------------------------------------------------
	localparam logic [2:0] PFMC_C_READ = 3'h1;
	localparam logic [2:0] PFMC_C_WRITE = 3'h2;
	localparam logic [2:0] PFMC_C_PROG = 3'h3;
	localparam logic [2:0] PFMC_C_RESET = 3'h4;
	localparam logic [2:0] PFMC_C_AUTOSEL = 3'h5;
	localparam logic [2:0] PFMC_C_PROTCHK = 3'h6;
	localparam logic [20:0] PFMC_UNLOCK1_A = 21'h000555;
	localparam logic [20:0] PFMC_UNLOCK2_A = 21'h0002aa;
	localparam logic [15:0] PFMC_UNLOCK1_D = 16'h00aa;
	localparam logic [15:0] PFMC_UNLOCK2_D = 16'h0055;
	localparam logic [15:0] PFMC_PROG_D = 16'h00a0;
	localparam logic [15:0] PFMC_AUTOSEL_D = 16'h0090;
	localparam logic [15:0] PFMC_RESET_D = 16'h00f0;
	// Autoselect address bits: qualifier low, item select, variant select
	localparam logic [20:0] PFMC_PROT_ITEM = 21'h000002;
	localparam int PFMC_VAR_BIT = 8;
	localparam int PFMC_SA_LSB = 12;
	localparam logic [7:0] PFMC_PROT_YES = 8'h01;
	localparam int PFMC_POLL_BIT = 7;
	localparam int PFMC_TOGG_BIT = 6;
	localparam int PFMC_TOUT_FLAG_BIT = 5;
	// ---------------------------------------------------------------
	// Bus timing
	// ---------------------------------------------------------------
	localparam int PFMC_CLK_NS = 10;
	localparam int PFMC_TACC_NS = 90;
	localparam int PFMC_TWP_NS = 35;
	localparam logic [3:0] PFMC_RD_CYC = 4'((PFMC_TACC_NS + PFMC_CLK_NS - 1) / PFMC_CLK_NS);
	localparam logic [3:0] PFMC_WR_CYC = 4'((PFMC_TWP_NS + PFMC_CLK_NS - 1) / PFMC_CLK_NS);

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic byte_n;
		logic [19:0] addr;
	} pfmc_ctl_s;

	typedef struct packed {
		logic [14:0] dq_o;
		logic [14:0] dq_oe_n;
		logic top_data_or_lsb_address_o;
		logic top_data_or_lsb_address_oe_n;
	} pfmc_dq_s;
endpackage : pfmc_pkg
`default_nettype wire

// ==== rtl/pfmc_host.sv ====
// Host controller for an asynchronous parallel NOR flash, driven from APB registers.
// Assumes the flash pins are wired directly; high-voltage reset is a request output.
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// - Host writes reset command after timeout flag or to leave autoselect.
// - Program is two unlock writes, set-up command, then address and data.
// - Protect other sectors before unprotecting; advisory only.
// - Autoselect reads: qualifier low, item bits zero or lo-bit high.
// - Protection verify: item hi high, lo low, sector on upper lines.
// - Manufacturer read with variant select high.
// - Autoselect by command sequence, no high voltage on the id pin.
module pfmc_host
	import pfmc_pkg::*;
(
	input wire logic pclk, // APB clock
	input wire logic presetn, // Async reset, low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [7:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output pfmc_pkg::pfmc_ctl_s flash_ctl, // Flash control and address
	output pfmc_pkg::pfmc_dq_s flash_dq, // Flash data drive
	input wire logic [14:0] dq_i, // Flash data in
	input wire logic top_data_or_lsb_address_i, // Top data line in
	output logic hv_reset_req // Request id high voltage on reset pin
);
	import pfmc_pkg::*;

	typedef enum logic [3:0] {
		PFMC_IDLE = 4'h0,
		PFMC_WSET = 4'h1,
		PFMC_WPUL = 4'h2,
		PFMC_WREC = 4'h3,
		PFMC_RACC = 4'h4,
		PFMC_RDONE = 4'h5,
		PFMC_POLL = 4'h6
	} pfmc_state_e;

	pfmc_state_e state_r;
	logic [3:0] cnt_r;
	logic [2:0] step_r;
	logic [2:0] cmd_r;
	logic word_r;
	logic hv_r;
	logic busy_r;
	logic tout_r;
	logic prot_r;
	logic [20:0] addr_r;
	logic [15:0] wdata_r;
	logic [15:0] rdata_r;
	logic [20:0] bus_a_r;
	logic [15:0] bus_d_r;
	logic [15:0] sync1_r;
	logic [15:0] sync2_r;
	logic [15:0] prev_r;
	logic poll_first_r;
	logic [15:0] din;
	logic wr_go;
	logic [2:0] nsteps;

	// ---------------------------------------------------------------
	// APB slave: always one access cycle; write to CTRL while not busy launches a command
	// ---------------------------------------------------------------
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign wr_go = psel && penable && pwrite && (paddr == PFMC_CTRL_OFF) && !busy_r;

	always_comb begin
		unique case (paddr)
			PFMC_CTRL_OFF: prdata = {26'h0, hv_r, word_r, 1'b0, cmd_r};
			PFMC_ADDR_OFF: prdata = {11'h0, addr_r};
			PFMC_WDATA_OFF: prdata = {16'h0, wdata_r};
			PFMC_RDATA_OFF: prdata = {16'h0, rdata_r};
			PFMC_STAT_OFF: prdata = {29'h0, prot_r, tout_r, busy_r};
			default: prdata = 32'h0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_r <= 21'h0;
			wdata_r <= 16'h0;
			cmd_r <= 3'h0;
			word_r <= 1'b1;
			hv_r <= 1'b0;
		end else if (psel && penable && pwrite) begin
			if (paddr == PFMC_ADDR_OFF)
				addr_r <= pwdata[20:0];
			if (paddr == PFMC_WDATA_OFF)
				wdata_r <= pwdata[15:0];
			if (paddr == PFMC_CTRL_OFF && !busy_r) begin
				cmd_r <= pwdata[PFMC_CMD_LSB +: PFMC_CMD_W];
				word_r <= pwdata[PFMC_WORD_BIT];
				hv_r <= pwdata[PFMC_HV_BIT];
			end
		end
	end
	assign hv_reset_req = hv_r; // software protects other sectors first

	// ---------------------------------------------------------------
	// Data input synchroniser
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync1_r <= 16'h0;
			sync2_r <= 16'h0;
		end else begin
			sync1_r <= {top_data_or_lsb_address_i, dq_i};
			sync2_r <= sync1_r;
		end
	end
	// Byte mode shows only the low byte; upper lines are don't-care
	assign din = word_r ? sync2_r : {8'h0, sync2_r[7:0]};

	// Number of write cycles per command, read follows on the last except for WRITE and RESET
	always_comb begin
		unique case (cmd_r)
			PFMC_C_PROG: nsteps = 3'h4;
			PFMC_C_AUTOSEL, PFMC_C_PROTCHK: nsteps = 3'h3;
			PFMC_C_READ: nsteps = 3'h0;
			default: nsteps = 3'h1;
		endcase
	end

	// ---------------------------------------------------------------
	// Bus address and data per sequence step
	// ---------------------------------------------------------------
	always_comb begin
		bus_a_r = addr_r;
		bus_d_r = wdata_r;
		if (cmd_r == PFMC_C_RESET) begin
			bus_d_r = PFMC_RESET_D;
		end else if (cmd_r != PFMC_C_WRITE && step_r < nsteps) begin
			unique case (step_r)
				3'h0: begin
					bus_a_r = PFMC_UNLOCK1_A;
					bus_d_r = PFMC_UNLOCK1_D;
				end
				3'h1: begin
					bus_a_r = PFMC_UNLOCK2_A;
					bus_d_r = PFMC_UNLOCK2_D;
				end
				3'h2: begin
					bus_a_r = PFMC_UNLOCK1_A;
					bus_d_r = (cmd_r == PFMC_C_PROG) ? PFMC_PROG_D : PFMC_AUTOSEL_D;
				end
				default: begin
					bus_a_r = addr_r;
					bus_d_r = wdata_r;
				end
			endcase
		end else if (cmd_r == PFMC_C_AUTOSEL) begin
			// Qualifier low, item bits and variant from the user address
			bus_a_r = addr_r & 21'h000103;
			bus_a_r[PFMC_VAR_BIT] = addr_r[PFMC_VAR_BIT];
		end else if (cmd_r == PFMC_C_PROTCHK) begin
			bus_a_r = ((addr_r >> PFMC_SA_LSB) << PFMC_SA_LSB) | PFMC_PROT_ITEM;
		end
	end

	// ---------------------------------------------------------------
	// Flash bus sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= PFMC_IDLE;
			cnt_r <= 4'h0;
			step_r <= 3'h0;
			busy_r <= 1'b0;
			tout_r <= 1'b0;
			prot_r <= 1'b0;
			rdata_r <= 16'h0;
			prev_r <= 16'h0;
			poll_first_r <= 1'b0;
		end else begin
			cnt_r <= (cnt_r == 4'h0) ? 4'h0 : cnt_r - 4'h1;
			unique case (state_r)
				PFMC_IDLE: begin
					step_r <= 3'h0;
					if (wr_go) begin
						busy_r <= 1'b1;
						tout_r <= 1'b0;
						state_r <= PFMC_WSET;
					end
				end
				PFMC_WSET: begin
					if (cmd_r == PFMC_C_READ || cmd_r == PFMC_C_RESET && step_r == 3'h1
						|| step_r >= nsteps && cmd_r != PFMC_C_RESET
						&& cmd_r != PFMC_C_WRITE && cmd_r != PFMC_C_PROG) begin
						cnt_r <= PFMC_RD_CYC;
						state_r <= PFMC_RACC;
					end else begin
						cnt_r <= PFMC_WR_CYC;
						state_r <= PFMC_WPUL;
					end
				end
				PFMC_WPUL: if (cnt_r == 4'h0) begin
					cnt_r <= PFMC_WR_CYC;
					state_r <= PFMC_WREC;
				end
				PFMC_WREC: if (cnt_r == 4'h0) begin
					step_r <= step_r + 3'h1;
					if (cmd_r == PFMC_C_PROG && step_r == 3'h3) begin
						poll_first_r <= 1'b1;
						cnt_r <= PFMC_RD_CYC;
						state_r <= PFMC_POLL;
					end else if (cmd_r == PFMC_C_WRITE || cmd_r == PFMC_C_RESET
						|| step_r + 3'h1 < nsteps) begin
						state_r <= (step_r + 3'h1 < nsteps) ? PFMC_WSET : PFMC_RDONE;
					end else begin
						state_r <= PFMC_WSET;
					end
				end
				PFMC_RACC: if (cnt_r == 4'h0) begin
					rdata_r <= din;
					prot_r <= (din[7:0] == PFMC_PROT_YES);
					state_r <= PFMC_RDONE;
				end
				PFMC_POLL: if (cnt_r == 4'h0) begin
					// Toggle bit moves once per read; oe_n rises while cnt_r is zero to split reads
					prev_r <= din;
					poll_first_r <= 1'b0;
					cnt_r <= PFMC_RD_CYC;
					if (!poll_first_r && din[PFMC_TOGG_BIT] == prev_r[PFMC_TOGG_BIT]) begin
						rdata_r <= din;
						tout_r <= (din[7:0] != wdata_r[7:0]);
						state_r <= PFMC_RDONE;
					end else if (din[PFMC_TOUT_FLAG_BIT] && !poll_first_r
						&& din[PFMC_POLL_BIT] != wdata_r[PFMC_POLL_BIT]) begin
						tout_r <= 1'b1;
						rdata_r <= din;
						state_r <= PFMC_RDONE;
					end
				end
				PFMC_RDONE: begin
					busy_r <= 1'b0;
					state_r <= PFMC_IDLE;
				end
				default: state_r <= PFMC_IDLE;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Pin drive
	// ---------------------------------------------------------------
	logic drive;
	assign drive = (state_r == PFMC_WSET || state_r == PFMC_WPUL || state_r == PFMC_WREC)
		&& !(cmd_r == PFMC_C_READ);
	always_comb begin
		flash_ctl.ce_n = (state_r == PFMC_IDLE || state_r == PFMC_RDONE);
		flash_ctl.oe_n = !(state_r == PFMC_RACC || (state_r == PFMC_POLL && |cnt_r));
		flash_ctl.we_n = (state_r != PFMC_WPUL);
		flash_ctl.byte_n = word_r;
		flash_ctl.addr = word_r ? bus_a_r[19:0] : bus_a_r[20:1];
		flash_dq.dq_o = bus_d_r[14:0];
		flash_dq.dq_oe_n = {{7{!(drive && word_r)}}, {8{!drive}}};
		flash_dq.top_data_or_lsb_address_o = word_r ? bus_d_r[15] : bus_a_r[0];
		flash_dq.top_data_or_lsb_address_oe_n = word_r ? !drive : 1'b0;
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_no_contend;
		@(posedge pclk) disable iff (!presetn) !flash_ctl.oe_n |-> &flash_dq.dq_oe_n;
	endproperty
	a_no_contend: assert property (p_no_contend) else $error("host drives during flash read");

	property p_byte_hiz;
		@(posedge pclk) disable iff (!presetn) !word_r |-> &flash_dq.dq_oe_n[14:8];
	endproperty
	a_byte_hiz: assert property (p_byte_hiz) else $error("upper lines driven in byte mode");

	property p_lsb_addr;
		@(posedge pclk) disable iff (!presetn)
			!word_r |-> !flash_dq.top_data_or_lsb_address_oe_n;
	endproperty
	a_lsb_addr: assert property (p_lsb_addr) else $error("byte address lsb not driven");

	property p_standby;
		@(posedge pclk) disable iff (!presetn) state_r == PFMC_IDLE |-> flash_ctl.ce_n && flash_ctl.oe_n;
	endproperty
	a_standby: assert property (p_standby) else $error("chip selected while idle");

	sequence s_prog_launch;
		state_r == PFMC_WREC && cmd_r == PFMC_C_PROG && step_r == 3'h3 && cnt_r == 4'h0;
	endsequence
	property p_prog_poll;
		@(posedge pclk) disable iff (!presetn) s_prog_launch |=> state_r == PFMC_POLL && busy_r;
	endproperty
	a_prog_poll: assert property (p_prog_poll) else $error("no polling after program");

	property p_no_cmd_busy;
		@(posedge pclk) disable iff (!presetn) state_r == PFMC_POLL |-> flash_ctl.we_n;
	endproperty
	a_no_cmd_busy: assert property (p_no_cmd_busy) else $error("write during program");

	property p_prot_addr;
		@(posedge pclk) disable iff (!presetn)
			state_r == PFMC_RACC && cmd_r == PFMC_C_PROTCHK && word_r
			|-> flash_ctl.addr[1:0] == 2'b10 && !flash_ctl.addr[6];
	endproperty
	a_prot_addr: assert property (p_prot_addr) else $error("bad verify address");

	property p_unlock_first;
		@(posedge pclk) disable iff (!presetn)
			state_r == PFMC_WPUL && cmd_r == PFMC_C_PROG && step_r == 3'h0
			|-> bus_d_r == PFMC_UNLOCK1_D;
	endproperty
	a_unlock_first: assert property (p_unlock_first) else $error("bad unlock data");

	property p_wr_width;
		@(posedge pclk) disable iff (!presetn)
			$fell(flash_ctl.we_n) |-> !flash_ctl.we_n [*5] ##1 flash_ctl.we_n;
	endproperty
	a_wr_width: assert property (p_wr_width) else $error("write pulse width wrong");
endmodule : pfmc_host
`default_nettype wire

// ==== sim/pfmc_flash_model.sv ====
// Behavioural parallel NOR flash: array, program, autoselect, one protected sector.
// Assumes pin levels from the host; the bench resolves the shared data lines.
`timescale 1ns/100ps
`default_nettype none
module pfmc_flash_model
	import pfmc_pkg::*;
#(
	parameter logic [15:0] MFR_ID = 16'h0033, // Arbitrary value
	parameter logic [15:0] DEV_ID = 16'h5aa5, // Arbitrary value
	parameter logic [7:0] CFG_ID = 8'h3c, // Arbitrary value
	parameter logic [7:0] PROT_SA = 8'h05, // Protected sector
	parameter int PROG_READS = 3, // Status reads while programming
	parameter int TACC = 60 // Access delay in ns
)(
	input wire pfmc_pkg::pfmc_ctl_s ctl, // Pins from host
	input wire logic lsb_i, // Byte address LSB
	input wire logic [15:0] wd, // Resolved data lines
	input wire logic hv, // Id high voltage on reset pin
	output logic [15:0] dq, // Read data
	output logic lo_en, // Low byte driven
	output logic hi_en // Upper lines driven
);
	logic [15:0] mem [int];
	logic [15:0] pdat;
	logic [15:0] rd;
	logic [19:0] pa;
	logic asel, busy, tgl;
	int step, left;
	initial begin
		mem[32'h100] = 16'h1234;
		{step, left, asel, busy, tgl} = '0;
	end
	function automatic logic [15:0] arr(input logic [19:0] a);
		return mem.exists(a) ? mem[a] : 16'hffff;
	endfunction : arr
	assign lo_en = !ctl.ce_n && !ctl.oe_n && ctl.we_n;
	assign hi_en = lo_en && ctl.byte_n;
	assign #TACC dq = rd;
	// ---------------------------------------------------------------
	// Command cycles, latched on the rising write strobe
	// ---------------------------------------------------------------
	always @(posedge ctl.we_n) begin
		if (!ctl.ce_n && !busy) begin
			if (wd[7:0] == 8'hf0) begin
				step = 0;
				asel = 1'b0;
			end else if (step == 3) begin
				step = 0;
				pa = ctl.addr;
				pdat = wd;
				busy = !(ctl.addr[19:12] == PROT_SA && !hv);
				left = PROG_READS;
			end else if (step == 0 && wd[7:0] == 8'haa && ctl.addr == 20'h555) step = 1;
			else if (step == 1 && wd[7:0] == 8'h55 && ctl.addr == 20'h2aa) step = 2;
			else if (step == 2 && wd[7:0] == 8'ha0) step = 3;
			else if (step == 2 && wd[7:0] == 8'h90) begin
				step = 0;
				asel = 1'b1;
			end else step = 0;
		end
	end
	// Each status read advances the internal algorithm
	always @(negedge ctl.oe_n) begin
		if (!ctl.ce_n && busy) begin
			tgl = !tgl;
			left = left - 1;
			if (left == 0) begin
				mem[pa] = arr(pa) & pdat;
				busy = 1'b0;
			end
		end
	end
	always @(ctl or busy or tgl or asel or lsb_i or hv or step) begin
		if (busy) rd = {8'h00, ~pdat[7], tgl, 6'h00};
		else if (!asel) rd = arr(ctl.addr);
		else if (ctl.addr[1:0] == 2'b10) rd = {15'h0, ctl.addr[19:12] == PROT_SA};
		else if (ctl.addr[0]) rd = DEV_ID;
		else rd = ctl.addr[8] ? MFR_ID : {8'h00, CFG_ID};
		if (!ctl.byte_n) rd = {8'h00, lsb_i ? rd[15:8] : rd[7:0]};
	end
endmodule : pfmc_flash_model
`default_nettype wire

// ==== sim/parallel_flash_mode_control_bench.sv ====
// Testbench for the flash host controller against the behavioural flash.
// Assumes APB access through registers; all inputs driven on rising edges.
`timescale 1ns/100ps
`default_nettype none
module parallel_flash_mode_control_bench
	import pfmc_pkg::*;
;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, hv, tog, flo, fhi;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q, st;
	logic [15:0] bus, fdq;
	pfmc_ctl_s ctl;
	pfmc_dq_s dqs;
	int miscompares, comparisons, cyc;
	pfmc_host dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .flash_ctl(ctl), .flash_dq(dqs), .dq_i(bus[14:0]),
		.top_data_or_lsb_address_i(bus[15]), .hv_reset_req(hv));
	pfmc_flash_model flash (.ctl(ctl), .lsb_i(bus[15]), .wd(bus), .hv(hv), .dq(fdq),
		.lo_en(flo), .hi_en(fhi));
	// Undriven lines flip every cycle so a stale value never passes
	for (genvar i = 0; i < 15; i++) begin : g_res
		assign bus[i] = !dqs.dq_oe_n[i] ? dqs.dq_o[i] : ((i < 8 ? flo : fhi) ? fdq[i] : tog);
	end
	assign bus[15] = !dqs.top_data_or_lsb_address_oe_n ? dqs.top_data_or_lsb_address_o :
		(fhi ? fdq[15] : tog);
	initial begin
		pclk = 1'b0;
		forever #5 pclk = !pclk;
	end
	always @(posedge pclk) begin
		tog <= !tog;
		cyc <= cyc + 1;
		if (!ctl.oe_n) chk("host drive in read", 32'h7fff, {17'h0, dqs.dq_oe_n});
		if (!ctl.byte_n) chk("upper lines", 32'h7f00, {17'h0, dqs.dq_oe_n & 15'h7f00});
		if (cyc == 20000) begin
			miscompares = miscompares + 1;
			end_sim();
		end
	end
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		comparisons = comparisons + 1;
		if (g !== e) begin
			miscompares = miscompares + 1;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		chk("slave error", 32'h0, {31'h0, pslverr});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Mode m is {high voltage, word}; leaves STAT in st and RDATA in q
	task automatic run(input logic [2:0] c, input logic [20:0] a, input logic [15:0] d,
		input logic [1:0] m);
		int n;
		apb(1'b1, PFMC_ADDR_OFF, {11'h0, a});
		apb(1'b1, PFMC_WDATA_OFF, {16'h0, d});
		apb(1'b1, PFMC_CTRL_OFF, {26'h0, m, 1'b0, c});
		n = 0;
		do begin
			apb(1'b0, PFMC_STAT_OFF, 32'h0);
			n++;
		end while (q[PFMC_BUSY_BIT] !== 1'b0 && n < 300);
		chk("busy", 32'h0, {31'h0, q[PFMC_BUSY_BIT]});
		st = q;
		apb(1'b0, PFMC_RDATA_OFF, 32'h0);
	endtask : run
	task automatic t_reset();
		chk("idle strobes", 32'h7, {29'h0, ctl.ce_n, ctl.oe_n, ctl.we_n});
		apb(1'b0, PFMC_CTRL_OFF, 32'h0);
		chk("ctrl reset", 32'h10, q);
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped read", 32'h0, q);
	endtask : t_reset
	task automatic t_prog();
		run(PFMC_C_READ, 21'h00100, 16'h0, 2'b01);
		chk("array read", 32'h1234, {16'h0, q[15:0]});
		run(PFMC_C_PROG, 21'h03000, 16'h0012, 2'b01);
		chk("program status", 32'h0, {31'h0, st[PFMC_TOUT_BIT]});
		run(PFMC_C_PROG, 21'h00002, 16'h00a5, 2'b01);
		run(PFMC_C_READ, 21'h00002, 16'h0, 2'b01);
		chk("lower sector data", 32'h00a5, {16'h0, q[15:0]});
		run(PFMC_C_PROG, 21'h03000, 16'h00ff, 2'b01);
		chk("set bit status", 32'h1, {31'h0, st[PFMC_TOUT_BIT]});
		run(PFMC_C_READ, 21'h03000, 16'h0, 2'b01);
		chk("set bit data", 32'h0012, {16'h0, q[15:0]});
	endtask : t_prog
	task automatic t_prot();
		run(PFMC_C_PROG, 21'h05010, 16'h0000, 2'b01);
		chk("protected status", 32'h1, {31'h0, st[PFMC_TOUT_BIT]});
		run(PFMC_C_PROTCHK, 21'h05010, 16'h0, 2'b01);
		chk("verify protected", 32'h101, {23'h0, st[PFMC_PROT_BIT], q[7:0]});
		run(PFMC_C_PROTCHK, 21'h03000, 16'h0, 2'b01);
		chk("verify open", 32'h0, {23'h0, st[PFMC_PROT_BIT], q[7:0]});
		run(PFMC_C_RESET, 21'h0, 16'h0, 2'b01);
		run(PFMC_C_PROG, 21'h05010, 16'h0000, 2'b11);
		chk("hv request", 32'h1, {31'h0, hv});
		run(PFMC_C_READ, 21'h05010, 16'h0, 2'b01);
		chk("unprotected data", 32'h0, {16'h0, q[15:0]});
	endtask : t_prot
	task automatic t_asel();
		run(PFMC_C_AUTOSEL, 21'h00100, 16'h0, 2'b01);
		chk("maker code", {16'h0, flash.MFR_ID}, {16'h0, q[15:0]});
		run(PFMC_C_AUTOSEL, 21'h00000, 16'h0, 2'b01);
		chk("config code", {24'h0, flash.CFG_ID}, {16'h0, q[15:0]});
		run(PFMC_C_AUTOSEL, 21'h00001, 16'h0, 2'b01);
		chk("device code", {16'h0, flash.DEV_ID}, {16'h0, q[15:0]});
		run(PFMC_C_RESET, 21'h0, 16'h0, 2'b01);
		run(PFMC_C_READ, 21'h00100, 16'h0, 2'b01);
		chk("read after reset", 32'h1234, {16'h0, q[15:0]});
		run(PFMC_C_AUTOSEL, 21'h00100, 16'h0, 2'b01);
		run(PFMC_C_WRITE, 21'h0, 16'h00f0, 2'b01);
		run(PFMC_C_READ, 21'h00100, 16'h0, 2'b01);
		chk("read after raw reset", 32'h1234, {16'h0, q[15:0]});
	endtask : t_asel
	task automatic t_byte();
		run(PFMC_C_READ, 21'h00201, 16'h0, 2'b00);
		chk("byte high", 32'h12, {24'h0, q[7:0]});
		run(PFMC_C_READ, 21'h00200, 16'h0, 2'b00);
		chk("byte low", 32'h34, {24'h0, q[7:0]});
	endtask : t_byte
	task automatic end_sim();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		{psel, penable, pwrite, tog} = '0;
		paddr = '0;
		pwdata = '0;
		cyc = 0;
		miscompares = 0;
		comparisons = 0;
		presetn = 1'b0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_prog();
		t_prot();
		t_asel();
		t_byte();
		end_sim();
	end
endmodule : parallel_flash_mode_control_bench
`default_nettype wire
